// *** core/srm_top.sv ***
// Start/reset element: start gating of monitored inputs, alarm reset and logic reset.
// Assumes pins are asynchronous, monitored element outputs and fault events share the clock.
`timescale 1ns/1ps

module srm_top
	import srm_pkg::*;
(
	input  wire logic                   clock,
	input  wire logic                   reset,
	input  wire logic [ADDR_W-1:0]      addr,
	input  wire logic [DATA_W-1:0]      wdata,
	input  wire logic                   wr_stb,
	input  wire logic                   rd_stb,
	output logic      [DATA_W-1:0]      rdata,
	input  wire logic [PIN_COUNT-1:0]   input_pins,
	input  wire logic                   func_button,
	input  wire logic [MON_COUNT-1:0]   monitored_inputs,
	input  wire logic [FAULT_COUNT-1:0] fault_events,
	input  wire logic                   fatal_event,
	output logic                        element_output,
	output logic                        alarm_ack,
	output logic                        logic_reset_out,
	output logic                        crosscheck_on,
	output logic      [FAULT_COUNT-1:0] faults_pending,
	output logic                        unrecoverable_fault_class
);

	// Synchronised pins and scan enable.
	logic [PIN_COUNT-1:0] pins_sync;
	logic                 func_sync;
	logic                 scan_tick;

	srm_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
		.clock    (clock),
		.reset    (reset),
		.async_in (input_pins),
		.sync_out (pins_sync)
	);

	srm_sync #(.WIDTH(1)) u_func_sync (
		.clock    (clock),
		.reset    (reset),
		.async_in (func_button),
		.sync_out (func_sync)
	);

	srm_scan_div #(.CYCLES(SCAN_CYCLES)) u_scan (
		.clock     (clock),
		.reset     (reset),
		.scan_tick (scan_tick)
	);

	// Configuration registers.
	srm_start_t       start_type_ff;
	logic             mon_en_ff;
	logic             alarm_en_ff;
	logic             logic_en_ff;
	logic             xchk_req_ff;
	logic [3:0]       btn_sel_ff;
	logic [MON_COUNT-1:0] mon_sel_ff;

	// Block state.
	logic                   first_aux_marker_ff;
	logic                   second_aux_marker_ff;
	logic                   element_output_ff;
	logic                   src_prev_ff;
	logic                   func_prev_ff;
	logic                   alarm_ack_ff;
	logic                   logic_reset_ff;
	logic                   crosscheck_ff;
	logic [FAULT_COUNT-1:0] fault_ff;
	logic                   fatal_ff;
	logic [DATA_W-1:0]      rdata_ff;

	// Register write decode.
	wire wr_ctrl_w   = wr_stb && (addr == ADDR_CTRL);
	wire wr_monsel_w = wr_stb && (addr == ADDR_MONSEL);
	wire [3:0] wr_sel_w  = wdata[CTRL_SEL_LSB +: 4];
	// An out-of-range button selection is dropped so the button stays on a basic input.
	wire       sel_ok_w  = (wr_sel_w <= BTN_SEL_MAX);

	// Configuration writes; one select field allows only one alarm button pin beside the function button.
	always_ff @(posedge clock) begin
		if (reset) begin
			start_type_ff <= srm_start_t'(RST_TYPE);
			mon_en_ff     <= 1'b0;
			alarm_en_ff   <= 1'b0;
			logic_en_ff   <= 1'b0;
			xchk_req_ff   <= 1'b0;
			btn_sel_ff    <= RST_SEL;
		end else if (wr_ctrl_w) begin
			start_type_ff <= srm_start_t'(wdata[CTRL_TYPE_LSB +: 2]);
			mon_en_ff     <= wdata[CTRL_MON_EN];
			alarm_en_ff   <= wdata[CTRL_ALARM_EN];
			logic_en_ff   <= wdata[CTRL_LOGIC_EN];
			xchk_req_ff   <= wdata[CTRL_XCHK_REQ];
			if (sel_ok_w) begin
				btn_sel_ff <= wr_sel_w;
			end
		end
	end

	// Monitored element selection mask.
	always_ff @(posedge clock) begin
		if (reset) begin
			mon_sel_ff <= RST_MONSEL;
		end else if (wr_monsel_w) begin
			mon_sel_ff <= wdata[MON_COUNT-1:0];
		end
	end

	// Switching input: all selected element outputs closed; nothing selected means open.
	wire sw_w  = (&(monitored_inputs | ~mon_sel_ff)) && (|mon_sel_ff);
	wire btn_w = pins_sync[btn_sel_ff];

	// Markers evaluated in list order, so marker two sees this scan's marker one.
	wire nxt_m1 = sw_w && (first_aux_marker_ff || btn_w);
	wire nxt_m2 = sw_w && (second_aux_marker_ff || (nxt_m1 && !btn_w));

	// Output select per start type; the reserved code keeps the output off.
	wire nxt_out = (start_type_ff == SRM_START_AUTO)    ? sw_w :
	               (start_type_ff == SRM_START_MANUAL)  ? nxt_m1 :
	               (start_type_ff == SRM_START_MONITOR) ? nxt_m2 : 1'b0;

	// Start logic runs once per scan cycle.
	always_ff @(posedge clock) begin
		if (reset) begin
			first_aux_marker_ff  <= 1'b0;
			second_aux_marker_ff <= 1'b0;
			element_output_ff    <= 1'b0;
		end else if (scan_tick) begin
			first_aux_marker_ff  <= nxt_m1;
			second_aux_marker_ff <= nxt_m2;
			element_output_ff    <= nxt_out;
		end
	end

	// Acknowledge sources. With start monitoring the selected button's release edge counts, so that
	// button shorted high can never acknowledge; otherwise, and always for the function button, the press edge counts.
	wire src_w     = alarm_en_ff && btn_w;
	wire src_rise  = src_w && !src_prev_ff;
	wire src_fall  = !src_w && src_prev_ff;
	wire src_edge  = mon_en_ff ? src_fall : src_rise;
	wire func_edge = func_sync && !func_prev_ff;
	wire nxt_ack   = scan_tick && (src_edge || func_edge);

	// Previous-scan levels and the one-cycle acknowledge pulse.
	always_ff @(posedge clock) begin
		if (reset) begin
			src_prev_ff    <= 1'b0;
			func_prev_ff   <= 1'b0;
			alarm_ack_ff   <= 1'b0;
			logic_reset_ff <= 1'b0;
		end else begin
			if (scan_tick) begin
				src_prev_ff  <= src_w;
				func_prev_ff <= func_sync;
			end
			alarm_ack_ff   <= nxt_ack;
			logic_reset_ff <= nxt_ack && logic_en_ff;
		end
	end

	// Latching faults hold until acknowledged; a new event beats the clear.
	wire [FAULT_COUNT-1:0] nxt_fault = fault_events |
	                                   (fault_ff & LATCH_MASK & {FAULT_COUNT{!alarm_ack_ff}});

	// Fault state; the fatal class ignores acknowledgement entirely.
	always_ff @(posedge clock) begin
		if (reset) begin
			fault_ff      <= '0;
			fatal_ff      <= 1'b0;
			crosscheck_ff <= 1'b0;
		end else begin
			fault_ff      <= nxt_fault;
			fatal_ff      <= fatal_ff || fatal_event;
			crosscheck_ff <= xchk_req_ff && !(alarm_en_ff || logic_en_ff);
		end
	end

	// Read selection; unmapped addresses read as zero.
	wire [DATA_W-1:0] ctrl_rd_w   = {20'h00000, btn_sel_ff, 2'h0, xchk_req_ff, logic_en_ff,
	                                 alarm_en_ff, mon_en_ff, start_type_ff};
	wire [DATA_W-1:0] status_rd_w = {26'h0000000, crosscheck_ff, btn_w, fatal_ff,
	                                 second_aux_marker_ff, first_aux_marker_ff,
	                                 element_output_ff};
	wire [DATA_W-1:0] rd_mux_w;
	assign rd_mux_w = (addr == ADDR_CTRL)   ? ctrl_rd_w :
	                  (addr == ADDR_MONSEL) ? {24'h000000, mon_sel_ff} :
	                  (addr == ADDR_STATUS) ? status_rd_w :
	                  (addr == ADDR_FAULTS) ? {15'h0000, fault_ff} : 32'h00000000;

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge clock) begin
		if (reset) begin
			rdata_ff <= 32'h00000000;
		end else begin
			rdata_ff <= rd_stb ? rd_mux_w : 32'h00000000;
		end
	end

	// Outputs come straight from flip-flops.
	assign rdata                     = rdata_ff;
	assign element_output            = element_output_ff;
	assign alarm_ack                 = alarm_ack_ff;
	assign logic_reset_out           = logic_reset_ff;
	assign crosscheck_on             = crosscheck_ff;
	assign faults_pending            = fault_ff;
	assign unrecoverable_fault_class = fatal_ff;

	// Checks on the start gating and acknowledgement.
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_auto_follow: assert property (
		scan_tick && start_type_ff == SRM_START_AUTO |=> element_output_ff == $past(sw_w))
		else $error("auto start output does not follow switching input");
	a_manual_set: assert property (
		scan_tick && start_type_ff == SRM_START_MANUAL && sw_w && btn_w
		|=> first_aux_marker_ff && element_output_ff)
		else $error("manual start did not set marker and output");
	a_open_clears: assert property (
		scan_tick && !sw_w |=> !first_aux_marker_ff && !second_aux_marker_ff && !element_output_ff)
		else $error("open circuit did not clear start state");
	a_held_nostart: assert property (
		scan_tick && btn_w && !second_aux_marker_ff |=> !second_aux_marker_ff)
		else $error("held start button produced monitored start");
	a_monitor_set: assert property (
		scan_tick && start_type_ff == SRM_START_MONITOR && first_aux_marker_ff && sw_w && !btn_w
		|=> second_aux_marker_ff && element_output_ff)
		else $error("monitored start did not start on release");
	a_ack_pulse: assert property (
		alarm_ack_ff |=> !alarm_ack_ff)
		else $error("acknowledge longer than one cycle");
	a_ack_needs_edge: assert property (
		alarm_ack_ff |-> $past(scan_tick))
		else $error("acknowledge outside a scan cycle");
	a_fatal_sticks: assert property (
		fatal_ff |=> fatal_ff)
		else $error("fatal fault cleared without restart");
	a_latch_holds: assert property (
		fault_ff[0] && !alarm_ack_ff |=> fault_ff[0])
		else $error("latching fault cleared without acknowledge");
	a_selfclear: assert property (
		!fault_events[2] |=> !fault_ff[2])
		else $error("self-clearing fault stayed set");
	a_xchk_forced: assert property (
		alarm_en_ff |=> !crosscheck_ff)
		else $error("cross check left on for reset input");
	a_logic_rst: assert property (
		logic_reset_ff |-> alarm_ack_ff)
		else $error("logic reset without acknowledge");
	a_sel_range: assert property (
		btn_sel_ff <= BTN_SEL_MAX)
		else $error("start button outside basic inputs");

	// Pulse sources, the sticky fatal state and refused selections.
	// These catch a broken gate that the level checks above would miss.
	a_logic_gate: assert property (
		alarm_ack_ff |-> logic_reset_ff == $past(logic_en_ff))
		else $error("logic reset not gated by its enable");
	a_ack_has_edge: assert property (
		alarm_ack_ff |-> $past(src_edge) || $past(func_edge))
		else $error("acknowledge without a button edge");
	a_fatal_sets: assert property (
		fatal_event |=> fatal_ff)
		else $error("fatal event not held");
	a_marker_order: assert property (
		second_aux_marker_ff |-> first_aux_marker_ff)
		else $error("second marker set without first marker");
	a_sel_refused: assert property (
		wr_ctrl_w && !sel_ok_w |=> btn_sel_ff == $past(btn_sel_ff))
		else $error("out of range button selection accepted");

	c_manual_start: cover property (
		start_type_ff == SRM_START_MANUAL && $rose(element_output_ff));
	c_monitor_start: cover property (
		start_type_ff == SRM_START_MONITOR && $rose(element_output_ff));
	c_ack: cover property (alarm_ack_ff && |fault_ff);
	c_logic_reset: cover property (logic_reset_ff);
	c_func_ack: cover property (alarm_ack_ff && $past(func_edge));

endmodule : srm_top

// *** pkg/srm_pkg.sv ***
// Constants, register map and types of the start/reset monitor.
// Assumes a single 200 MHz clock and a plain register port with 8-bit byte addresses.
package srm_pkg;

	// Clock and scan cycle timing.
	localparam int CLOCK_PERIOD_NS = 5;
	localparam int SCAN_PERIOD_NS  = 1000;
	localparam int SCAN_CYCLES     = (SCAN_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	// Widths.
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;
	localparam int PIN_COUNT  = 14;
	localparam int MON_COUNT  = 8;
	localparam int FAULT_COUNT = 17;

	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_MONSEL = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_FAULTS = 8'h0C;

	// Control register fields.
	localparam int CTRL_TYPE_LSB  = 0;
	localparam int CTRL_MON_EN    = 2;
	localparam int CTRL_ALARM_EN  = 3;
	localparam int CTRL_LOGIC_EN  = 4;
	localparam int CTRL_XCHK_REQ  = 5;
	localparam int CTRL_SEL_LSB   = 8;
	localparam logic [3:0] BTN_SEL_MAX = 4'hD;

	// Values after reset.
	localparam logic [1:0] RST_TYPE   = 2'h0;
	localparam logic [3:0] RST_SEL    = 4'h0;
	localparam logic [7:0] RST_MONSEL = 8'h01;

	// Fault classes: a set bit latches until acknowledged, a clear bit self-clears.
	localparam logic [16:0] LATCH_MASK = 17'h10FCB;

	// Start types.
	typedef enum logic [1:0] {
		SRM_START_AUTO    = 2'b00,
		SRM_START_MANUAL  = 2'b01,
		SRM_START_MONITOR = 2'b10,
		SRM_START_RSVD    = 2'b11
	} srm_start_t;

endpackage : srm_pkg

// *** core/srm_sync.sv ***
// Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes each bit is a slow level; no bus coherence across bits is promised.
`timescale 1ns/1ps
module srm_sync
	import srm_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// The first stage feeds only the second stage.
	always_ff @(posedge clock) begin
		if (reset) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule : srm_sync

// *** core/srm_scan_div.sv ***
// Divider that turns the clock into a one-cycle scan cycle enable.
// Assumes the clock runs continuously; the first tick follows a full period after reset.
`timescale 1ns/1ps
module srm_scan_div
	import srm_pkg::*;
#(
	parameter int CYCLES = SCAN_CYCLES
) (
	input  wire logic clock,
	input  wire logic reset,
	output logic      scan_tick
);

	logic [15:0] count_ff;
	logic        tick_ff;
	wire         wrap_w = (count_ff == 16'(CYCLES - 1));

	// Count up and wrap, pulsing once per period.
	always_ff @(posedge clock) begin
		if (reset) begin
			count_ff <= 16'h0000;
			tick_ff  <= 1'b0;
		end else begin
			count_ff <= wrap_w ? 16'h0000 : count_ff + 16'h0001;
			tick_ff  <= wrap_w;
		end
	end

	assign scan_tick = tick_ff;

endmodule : srm_scan_div

// *** bench/srm_partner.sv ***
// Far side: safety circuit contacts, normally open push buttons and a user RS store.
// Assumes the bench sets wanted levels; every level moves just after a rising edge.
`timescale 1ns/1ps
module srm_partner
	import srm_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic [3:0]           btn_sel,
	input  wire logic                 press,
	input  wire logic                 func_press,
	input  wire logic [MON_COUNT-1:0] closed,
	input  wire logic                 store_set,
	input  wire logic                 logic_reset_out,
	output logic      [PIN_COUNT-1:0] input_pins,
	output logic                      func_button,
	output logic      [MON_COUNT-1:0] monitored_inputs,
	output logic                      stored_fault_ff
);
	// Everything starts released and open, so no input is unknown at time zero.
	initial begin
		{input_pins, func_button, monitored_inputs, stored_fault_ff} = '0;
	end
	// A released contact reads 0 through its pull-down; only the wired pin sees the press.
	always @(posedge clock) begin
		input_pins <= PIN_COUNT'(press) << btn_sel;
		func_button <= func_press;
		monitored_inputs <= closed;
	end
	// User RS store keeps a self-clearing fault until the logic reset pulse.
	always @(posedge clock) begin
		if (logic_reset_out) begin
			stored_fault_ff <= 1'b0;
		end else if (store_set) begin
			stored_fault_ff <= 1'b1;
		end
	end
endmodule : srm_partner

// *** bench/tb_top.sv ***
// Self-checking bench of the start/reset monitor with a behavioural start model.
// Assumes the fixed 200-clock scan tick; waits of 450 clocks span two ticks.
`timescale 1ns/1ps
module tb_top
	import srm_pkg::*;
;
	logic                   clock = 1'b0;
	logic                   reset = 1'b1;
	logic [ADDR_W-1:0]      addr = '0;
	logic [DATA_W-1:0]      wdata = '0;
	logic                   wr_stb = 1'b0;
	logic                   rd_stb = 1'b0;
	logic [DATA_W-1:0]      rdata;
	logic [PIN_COUNT-1:0]   input_pins;
	logic                   func_button;
	logic [MON_COUNT-1:0]   monitored_inputs;
	logic [FAULT_COUNT-1:0] fault_events = '0;
	logic                   fatal_event = 1'b0;
	logic                   element_output;
	logic                   alarm_ack;
	logic                   logic_reset_out;
	logic                   crosscheck_on;
	logic [FAULT_COUNT-1:0] faults_pending;
	logic                   unrecoverable_fault_class;
	logic                   stored_fault_ff;
	logic [3:0]             btn_sel = 4'h0;
	logic                   press = 1'b0;
	logic                   func_press = 1'b0;
	logic [MON_COUNT-1:0]   closed = '0;
	logic [31:0]            d;
	logic [7:0]             m;
	logic [7:0]             v;
	int                     n_fail = 0;
	int                     n_compared = 0;
	int                     n_ack = 0;
	int                     n_lr = 0;
	int                     m1 = 0;
	int                     m2 = 0;
	int                     e;
	int                     sw_tab[4] = '{1, 1, 1, 0};
	int                     btn_tab[4] = '{0, 1, 0, 0};

	srm_top srm_top_inst (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .input_pins(input_pins),
		.func_button(func_button), .monitored_inputs(monitored_inputs),
		.fault_events(fault_events), .fatal_event(fatal_event),
		.element_output(element_output), .alarm_ack(alarm_ack),
		.logic_reset_out(logic_reset_out), .crosscheck_on(crosscheck_on),
		.faults_pending(faults_pending), .unrecoverable_fault_class(unrecoverable_fault_class));
	srm_partner srm_partner_inst (.clock(clock), .btn_sel(btn_sel), .press(press),
		.func_press(func_press), .closed(closed), .store_set(faults_pending[2]),
		.logic_reset_out(logic_reset_out), .input_pins(input_pins),
		.func_button(func_button), .monitored_inputs(monitored_inputs),
		.stored_fault_ff(stored_fault_ff));

	// Free-running 200 MHz clock.
	always #2.5 clock = ~clock;
	// Pulses are counted so that a held level giving repeated acks is seen.
	always @(posedge clock) begin
		n_ack += (alarm_ack === 1'b1);
		n_lr += (logic_reset_out === 1'b1);
	end

	task automatic report_and_stop();
		if (n_fail == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] ex);
		n_compared++;
		if (seen !== ex) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, ex, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		@(posedge clock);
		addr <= a;
		wdata <= dv;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(input logic [7:0] a, output logic [31:0] dv);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		@(negedge clock);
		dv = rdata;
	endtask : rd
	task automatic scans();
		repeat (450) @(posedge clock);
		@(negedge clock);
	endtask : scans
	// One event cycle on every fault function and on the fatal line.
	task automatic fault_pulse();
		@(posedge clock);
		fault_events <= '1;
		fatal_event <= 1'b1;
		@(posedge clock);
		fault_events <= '0;
		fatal_event <= 1'b0;
		repeat (3) @(negedge clock);
		check("faults_latched", 32'(faults_pending), 32'(LATCH_MASK));
	endtask : fault_pulse
	// Reference start logic: markers evaluated in list order within one scan.
	task automatic model_step(input int typ, input int sw, input int btn, output int o);
		if (sw == 0) begin
			m1 = 0;
			m2 = 0;
		end
		if (sw != 0 && btn != 0) begin
			m1 = 1;
		end
		if (sw != 0 && m1 != 0 && btn == 0) begin
			m2 = 1;
		end
		o = (typ == 0) ? sw : (typ == 1) ? (m1 & sw) : (typ == 2) ? (m2 & sw) : 0;
	endtask : model_step

	// Watchdog sized well above the roughly 13000 clocks that the tests need.
	initial begin
		repeat (60000) @(posedge clock);
		n_fail++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'hC9FA));
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		check("element_output", 32'(element_output), 32'h0);
		rd(ADDR_STATUS, d);
		check("status", 32'(d[2:0]), 32'h0);
		rd(ADDR_MONSEL, d);
		check("monsel", 32'(d[7:0]), 32'(RST_MONSEL));
		rd(8'h10, d);
		check("unmapped", d, 32'h0);
		// Every start type walks through the same contact and button sequence.
		for (int t = 0; t < 4; t++) begin
			wr(ADDR_CTRL, 32'(t));
			for (int s = 0; s < 4; s++) begin
				closed <= (sw_tab[s] != 0) ? 8'hFF : 8'h00;
				press <= btn_tab[s][0];
				scans();
				model_step(t, sw_tab[s], btn_tab[s], e);
				check("element_output", 32'(element_output), 32'(e));
			end
		end
		check("ack_disabled", 32'(n_ack), 32'h0);
		wr(ADDR_CTRL, 32'h0);
		// Random contact sets against an empty monitor mask, then random masks.
		for (int i = 0; i < 6; i++) begin
			m = (i == 0) ? 8'h00 : 8'($urandom());
			v = (i[0]) ? (8'($urandom()) | m) : 8'($urandom());
			wr(ADDR_MONSEL, 32'(m));
			closed <= v;
			scans();
			check("element_output", 32'(element_output), 32'(m != 0 && (v & m) == m));
		end
		wr(ADDR_CTRL, 32'h00000E00);
		rd(ADDR_CTRL, d);
		check("button_sel", 32'(d[11:8]), 32'h0);
		wr(ADDR_CTRL, 32'h00000D20);
		rd(ADDR_CTRL, d);
		check("button_sel", 32'(d[11:8]), 32'(BTN_SEL_MAX));
		check("crosscheck_on", 32'(crosscheck_on), 32'h1);
		wr(ADDR_CTRL, 32'h00000338);
		rd(ADDR_STATUS, d);
		check("crosscheck_off", 32'({crosscheck_on, d[5]}), 32'h0);
		btn_sel <= 4'h3;
		fault_pulse();
		check("user_store", 32'(stored_fault_ff), 32'h1);
		e = n_ack;
		press <= 1'b1;
		scans();
		scans();
		check("ack_count", 32'(n_ack - e), 32'h1);
		check("logic_reset_count", 32'(n_lr - e), 32'h1);
		check("faults_pending", 32'(faults_pending), 32'h0);
		check("user_store", 32'(stored_fault_ff), 32'h0);
		check("fatal", 32'(unrecoverable_fault_class), 32'h1);
		press <= 1'b0;
		scans();
		fault_pulse();
		e = n_ack;
		func_press <= 1'b1;
		scans();
		func_press <= 1'b0;
		check("func_ack", 32'(n_ack - e), 32'h1);
		check("faults_pending", 32'(faults_pending), 32'h0);
		check("fatal", 32'(unrecoverable_fault_class), 32'h1);
		wr(ADDR_CTRL, 32'h0000033C);
		scans();
		fault_pulse();
		e = n_ack;
		press <= 1'b1;
		scans();
		check("ack_on_press", 32'(n_ack - e), 32'h0);
		press <= 1'b0;
		scans();
		check("ack_on_release", 32'(n_ack - e), 32'h1);
		check("faults_pending", 32'(faults_pending), 32'h0);
		report_and_stop();
	end
endmodule : tb_top
